//--- acs_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit word bus with one register per aligned word
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================
// offsets
`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_DATA 8'h04
`define ACS_OFS_CLK 8'h08
`define ACS_OFS_PORT 8'h0C
`define ACS_OFS_DIR 8'h10

// ==========================================
// fields
`define ACS_CTRL_DONE 7
`define ACS_CTRL_IEN 6
`define ACS_CTRL_CONT 5
`define ACS_CLK_DIV_HI 7
`define ACS_CLK_DIV_LO 5
`define ACS_CLK_SEL 4

// ==========================================
// reset values and codes
`define ACS_CTRL_RST 8'h1F
`define ACS_CLK_RST 8'h00
`define ACS_CH_OFF 5'h1F
`define ACS_CH_REFH 5'h1D
`define ACS_CH_REFL 5'h1E
`define ACS_SAR_FIRST 8'h80

// ==========================================
// timing: converter clocks per conversion, last index
`define ACS_CONV_TICKS 16
`define ACS_LAST_TICK 4'hF

`endif

//--- acs_pkg.sv
// types shared by the sequencer and its bench
// assumes acs_regs.svh for all numeric constants
`default_nettype none
package acs_pkg;

    typedef enum logic [0:0] {
        ACS_IDLE = 1'b0,
        ACS_CONV = 1'b1
    } acs_state_type;

    // signals towards the analog mux and converter core
    typedef struct packed {
        logic power;
        logic sample;
        logic [4:0] chan;
        logic [7:0] dac;
    } acs_core_type;

endpackage

`default_nettype wire

//--- acs_sequencer.sv
// conversion sequencer for an 8-bit successive approximation converter
// assumes an AHB-Lite master, an analog core with comparator output,
// and eight port pins shared between general I/O and the converter
//
// Summary of operation
// - every control register write outside stop mode with a channel code other than 1F starts a conversion of the selected channel
// - a conversion takes 16 to 17 converter clock cycles
// - continuous mode overwrites the result register, read or not
// - continuous bit set restarts after each completion until cleared
// - interrupts off: done flag set at completion, cleared by result read
// - single mode does one conversion per control write, then idles
// - interrupt enabled raises a request at every completion
// - interrupts on: done flag stays zero
// - selected pin is forced to converter input, others stay with port logic
// - port data and direction writes do not affect the selected pin
// - port read of the selected pin returns zero
// - result is straight binary, high reference FF, low reference 00
// - conversions run in wait mode; request can wake the processor
// - stop mode aborts any conversion with no result
// - after stop ends, conversions resume; software allows one settling cycle
// - 8-bit results from one of eight pin channels or the two references by channel select field
// - channel codes 0-7 pins, 1D high ref, 1E low ref, 1F power off
// - pending request withdrawn on result read or control write
// - divider 1,2,4,8 for 000-011 and 16 for 1xx; select bus or crystal
// - reset clears flag, enable, continuous; channel all ones; crystal source
`timescale 1ns/1ns
`include "acs_regs.svh"
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // clock source and low power
    input wire logic crystal_clock_i,
    input wire logic stop_mode_i,
    output logic conv_irq_o,
    // converter core
    input wire logic comparator_i,
    output acs_core_type core_o,
    // shared analog pins
    input wire logic [PINS-1:0] shared_analog_pins_i,
    output logic [PINS-1:0] shared_analog_pins_o,
    output logic [PINS-1:0] shared_analog_pins_oe_o,
    output logic [PINS-1:0] analog_select_o
);

    // ==========================================
    // functions

    // last count of the prescaler for a divide code
    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [3:0] r;
        r = 4'hF;
        case (code)
            3'h0: r = 4'h0;
            3'h1: r = 4'h1;
            3'h2: r = 4'h3;
            3'h3: r = 4'h7;
            default: r = 4'hF;
        endcase
        return r;
    endfunction

    // decide bit idx by comparator, then try the next lower bit
    function automatic logic [7:0] sar_step(input logic [7:0] sar,
                                            input logic [2:0] idx,
                                            input logic keep);
        logic [7:0] r;
        r = sar;
        r[idx] = keep;
        if (idx != 3'h0) begin
            r[idx - 3'h1] = 1'b1;
        end
        return r;
    endfunction

    // ==========================================
    // reset release and input synchronisers
    logic rst_s1_ff, rst_n;
    logic xt_s1_ff, xt_s2_ff, xt_d_ff;
    logic cmp_s1_ff, cmp_s2_ff;
    logic [PINS-1:0] pin_s1_ff, pin_s2_ff;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n <= rst_s1_ff;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            xt_s1_ff <= 1'b0;
            xt_s2_ff <= 1'b0;
            xt_d_ff <= 1'b0;
            cmp_s1_ff <= 1'b0;
            cmp_s2_ff <= 1'b0;
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            xt_s1_ff <= crystal_clock_i;
            xt_s2_ff <= xt_s1_ff;
            xt_d_ff <= xt_s2_ff;
            cmp_s1_ff <= comparator_i;
            cmp_s2_ff <= cmp_s1_ff;
            pin_s1_ff <= shared_analog_pins_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ==========================================
    // registers and state
    logic ien_ff, cont_ff, done_ff, irq_ff;
    logic [4:0] ch_ff;
    logic [7:0] clk_ff, result_ff, sar_ff, port_ff, dir_ff;
    logic [3:0] div_ff, cnt_ff;
    acs_state_type state_ff;
    logic stop_ff, resume_ff, first_ff;
    logic wr_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff;

    // ==========================================
    // bus decode
    wire logic addr_valid = hsel_i & htrans_i[1] & hready_i;
    wire logic rd_act = addr_valid & ~hwrite_i;
    wire logic ctrl_wr = wr_ff & (addr_ff == `ACS_OFS_CTRL);
    wire logic clk_wr = wr_ff & (addr_ff == `ACS_OFS_CLK);
    wire logic port_wr = wr_ff & (addr_ff == `ACS_OFS_PORT);
    wire logic dir_wr = wr_ff & (addr_ff == `ACS_OFS_DIR);
    wire logic data_rd = rd_act & (haddr_i == `ACS_OFS_DATA);
    wire logic [4:0] ch_new = hwdata_i[4:0];

    // ==========================================
    // pin sharing
    wire logic ch_on = (ch_ff != `ACS_CH_OFF);
    wire logic pin_ch = (ch_ff[4:3] == 2'h0);
    wire logic [PINS-1:0] sel_mask = pin_ch ? (PINS'(1) << ch_ff[2:0]) : '0;
    wire logic [PINS-1:0] port_rd = ((dir_ff & port_ff) | (~dir_ff & pin_s2_ff))
                                    & ~sel_mask;

    // flag reads zero with requests on
    wire logic [7:0] ctrl_rd = {done_ff & ~ien_ff, ien_ff, cont_ff, ch_ff};
    wire logic [7:0] rd_mux =
        (haddr_i == `ACS_OFS_CTRL) ? ctrl_rd :
        (haddr_i == `ACS_OFS_DATA) ? result_ff :
        (haddr_i == `ACS_OFS_CLK) ? clk_ff :
        (haddr_i == `ACS_OFS_PORT) ? port_rd :
        (haddr_i == `ACS_OFS_DIR) ? dir_ff : 8'h00;

    // ==========================================
    // converter clock enable
    // source and divide select
    wire logic in_edge = clk_ff[`ACS_CLK_SEL] | (xt_s2_ff & ~xt_d_ff);
    wire logic [3:0] last = div_last(clk_ff[`ACS_CLK_DIV_HI:`ACS_CLK_DIV_LO]);
    wire logic tick = in_edge & (div_ff >= last);
    wire logic [3:0] nxt_div = tick ? 4'h0 : (in_edge ? div_ff + 4'h1 : div_ff);

    // ==========================================
    // sequencing
    wire logic busy = (state_ff == ACS_CONV);
    wire logic stop_exit = stop_ff & ~stop_mode_i;
    // first tick only aligns, sixteen full ticks follow
    // the aligning tick may be partial, so a conversion spans 16 to 17 periods
    wire logic step = busy & tick & ~first_ff;
    wire logic done_evt = step & (cnt_ff == `ACS_LAST_TICK)
                          & ~stop_mode_i & ~ctrl_wr;
    // a write mid-conversion restarts from step one unless its channel code is all ones
    wire logic start_wr = ctrl_wr & (ch_new != `ACS_CH_OFF) & ~stop_mode_i;
    wire logic start_cont = done_evt & cont_ff;
    wire logic start_res = stop_exit & resume_ff & ~ctrl_wr;
    wire logic conv_go = start_wr | start_cont | start_res;
    // single mode idles after one result
    wire logic to_idle = stop_mode_i | ctrl_wr | done_evt;
    wire acs_state_type nxt_state = conv_go ? ACS_CONV :
                                    (to_idle ? ACS_IDLE : state_ff);
    wire logic [3:0] nxt_cnt = conv_go ? 4'h0 : (step ? cnt_ff + 4'h1 : cnt_ff);
    wire logic nxt_first = conv_go | (first_ff & ~tick);
    // msb first trial gives straight binary
    wire logic [7:0] sar_dec = sar_step(sar_ff, ~cnt_ff[2:0], cmp_s2_ff);
    wire logic [7:0] nxt_sar = conv_go ? `ACS_SAR_FIRST :
                               ((step & cnt_ff[3]) ? sar_dec : sar_ff);
    wire logic nxt_resume = stop_mode_i ? (resume_ff | busy | cont_ff) :
                            ((stop_exit | ctrl_wr) ? 1'b0 : resume_ff);

    // ==========================================
    // completion flag and request
    // flag set only with interrupts off; set wins over read clear
    wire logic nxt_done = (done_evt & ~ien_ff) | (done_ff & ~data_rd);
    // withdrawn on result read or control write, set wins over a read
    wire logic nxt_irq = (done_evt & ien_ff) | (irq_ff & ~data_rd & ~ctrl_wr);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ACS_IDLE;
            cnt_ff <= 4'h0;
            sar_ff <= 8'h00;
            div_ff <= 4'h0;
            stop_ff <= 1'b0;
            resume_ff <= 1'b0;
            first_ff <= 1'b0;
            done_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sar_ff <= nxt_sar;
            div_ff <= nxt_div;
            stop_ff <= stop_mode_i;
            resume_ff <= nxt_resume;
            first_ff <= nxt_first;
            done_ff <= nxt_done;
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= 8'h00;
        end else if (done_evt) begin
            result_ff <= sar_dec;
        end
    end

    // ==========================================
    // software registers
    // reset values
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ien_ff <= 1'b0;
            cont_ff <= 1'b0;
            ch_ff <= `ACS_CH_OFF;
            clk_ff <= `ACS_CLK_RST;
            port_ff <= 8'h00;
            dir_ff <= 8'h00;
        end else begin
            if (ctrl_wr) begin
                ien_ff <= hwdata_i[`ACS_CTRL_IEN];
                cont_ff <= hwdata_i[`ACS_CTRL_CONT];
                ch_ff <= ch_new;
            end
            if (clk_wr) begin
                clk_ff <= {hwdata_i[7:4], 4'h0};
            end
            if (port_wr) begin
                port_ff <= hwdata_i[7:0];
            end
            if (dir_wr) begin
                dir_ff <= hwdata_i[7:0];
            end
        end
    end

    // ==========================================
    // bus data phase, zero wait states
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
            hrdata_ff <= 32'h0;
        end else begin
            wr_ff <= addr_valid & hwrite_i;
            if (addr_valid) begin
                addr_ff <= haddr_i;
            end
            if (rd_act) begin
                hrdata_ff <= {24'h0, rd_mux};
            end
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_ff;

    // request stays live in wait, it is the wake source
    assign conv_irq_o = irq_ff;

    // channel code passed to the mux, all ones powers off
    // order: power, sample, chan, dac
    assign core_o = {ch_on, busy & ~cnt_ff[3], ch_ff, sar_ff};

    // selected pin handed to the converter
    // port latches cannot drive the selected pin
    assign shared_analog_pins_o = port_ff & ~sel_mask;
    assign shared_analog_pins_oe_o = dir_ff & ~sel_mask;
    assign analog_select_o = sel_mask;

endmodule

`default_nettype wire

//--- acs_chk.sv
// port checker for the conversion sequencer
// assumes it is bound onto acs_sequencer
`timescale 1ns/1ns
`include "acs_regs.svh"
`default_nettype none
module acs_chk
    import acs_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock, reset, bus
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    // converter and pins
    input wire logic stop_mode_i,
    input wire logic conv_irq_o,
    input wire acs_core_type core_o,
    input wire logic [PINS-1:0] shared_analog_pins_o,
    input wire logic [PINS-1:0] shared_analog_pins_oe_o,
    input wire logic [PINS-1:0] analog_select_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic taken = hsel_i & htrans_i[1] & hready_i;
    wire logic rd_data = taken & !hwrite_i & (haddr_i == `ACS_OFS_DATA);
    wire logic wr_ctrl = taken & hwrite_i & (haddr_i == `ACS_OFS_CTRL);
    wire logic [PINS-1:0] sel_exp = (core_o.chan < 5'h08) ?
        PINS'(1) << core_o.chan[2:0] : '0;
    // registered pin terms may lag a select change by a cycle
    sequence sel_steady;
        $stable(analog_select_o) ##1 $stable(analog_select_o);
    endsequence
    // ==========================================
    // assertions
    chk_select_chan: assert property (analog_select_o == sel_exp)
        else $error("pin select does not follow channel");
    chk_pin_masked: assert property (sel_steady |->
        (shared_analog_pins_o & analog_select_o) == '0)
        else $error("selected pin still driven with data");
    chk_oe_masked: assert property (sel_steady |->
        (shared_analog_pins_oe_o & analog_select_o) == '0)
        else $error("selected pin output enabled");
    chk_irq_read_clr: assert property (rd_data |=> !conv_irq_o)
        else $error("request kept after result read");
    chk_irq_write_clr: assert property (wr_ctrl |-> ##2 !conv_irq_o)
        else $error("request kept after control write");
    chk_power_chan: assert property (core_o.power == (core_o.chan != `ACS_CH_OFF))
        else $error("power does not match channel code");
    chk_sample_first: assert property (core_o.sample |-> core_o.dac == `ACS_SAR_FIRST)
        else $error("sampling without first trial code");
    chk_stop_quiet: assert property (stop_mode_i ##1 stop_mode_i |->
        !core_o.sample && !$rose(conv_irq_o))
        else $error("activity during stop");
    cover property ($rose(conv_irq_o));
    cover property (stop_mode_i ##1 stop_mode_i);
    cover property (rd_data && conv_irq_o);
endmodule
bind acs_sequencer acs_chk #(.PINS(PINS)) u_chk (.clock_i, .rst_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .stop_mode_i, .conv_irq_o, .core_o,
    .shared_analog_pins_o, .shared_analog_pins_oe_o, .analog_select_o);
`default_nettype wire

//--- acs_core_model.sv
// behavioural analog mux and comparator
// assumes levels per pin channel are given by the bench
`timescale 1ns/1ns
`include "acs_regs.svh"
`default_nettype none
module acs_core_model
    import acs_pkg::*;
(
    // clock and core control
    input wire logic clock_i,
    input wire acs_core_type core_i,
    input wire logic [63:0] levels_i,
    // comparator decision
    output logic comparator_o
);
    logic idle_ff = 1'b0;
    logic [7:0] vin;
    assign vin = (core_i.chan < 5'h08) ? levels_i[core_i.chan[2:0]*8 +: 8] :
        (core_i.chan == `ACS_CH_REFH) ? 8'hFF :
        (core_i.chan == `ACS_CH_REFL) ? 8'h00 : 8'h5A;
    // unpowered core gives no steady decision
    always @(posedge clock_i) begin
        idle_ff <= ~idle_ff;
    end
    assign comparator_o = core_i.power ? (vin >= core_i.dac) : idle_ff;
endmodule
`default_nettype wire

//--- acs_sequencer_tb.sv
// self-checking bench for the conversion sequencer
// assumes acs_core_model as the analog side
`timescale 1ns/1ns
`include "acs_regs.svh"
`default_nettype none
module acs_sequencer_tb;
    import acs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, xclk = 1'b0, stop = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hreadyout, hresp, irq, cmp;
    logic [7:0] pins_o, pins_oe, sel;
    acs_core_type core;
    logic [63:0] levels = 64'h3C_C3_80_7F_5A_E1_01_A5;
    logic [2:0] dv [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
    int dd [4] = '{4, 8, 16, 16};
    logic [4:0] chs [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1D, 5'h1E};
    int error_cnt = 0, total_checks = 0, cyc = 0, n;
    always #5 clk = ~clk;
    always #41 xclk = ~xclk;
    acs_sequencer u_dut (.clock_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .crystal_clock_i(xclk), .stop_mode_i(stop), .conv_irq_o(irq), .comparator_i(cmp),
        .core_o(core), .shared_analog_pins_i(8'hFF), .shared_analog_pins_o(pins_o),
        .shared_analog_pins_oe_o(pins_oe), .analog_select_o(sel));
    acs_core_model u_core (.clock_i(clk), .core_i(core), .levels_i(levels), .comparator_o(cmp));
    // ==========================================
    // tasks
    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
        check(hresp, 1'b0);
    endtask
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
    endtask
    function automatic logic [31:0] expv(input logic [4:0] c);
        if (c == `ACS_CH_REFH) return 32'hFF;
        if (c == `ACS_CH_REFL) return 32'h00;
        return {24'h0, levels[c[2:0]*8 +: 8]};
    endfunction
    // ==========================================
    // sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(`ACS_OFS_CTRL, 32'h1F);
        rd_chk(`ACS_OFS_CLK, 32'h00);
        rd_chk(8'h14, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`ACS_OFS_CLK, {24'h0, dv[i], 5'h10});
            rd_chk(`ACS_OFS_CLK, {24'h0, dv[i], 5'h10});
            wr(`ACS_OFS_CTRL, 32'h47);
            wait_irq();
            check(n > 16 * dd[i] && n <= 17 * dd[i] + 2, 1'b1);
            rd_chk(`ACS_OFS_CTRL, 32'h47);
            rd_chk(`ACS_OFS_DATA, expv(5'h07));
            check(irq, 1'b0);
        end
        wr(`ACS_OFS_CLK, 32'h50);
        foreach (chs[i]) begin
            wr(`ACS_OFS_CTRL, {27'h0, chs[i]});
            repeat (80) @(posedge clk);
            rd_chk(`ACS_OFS_CTRL, {27'h4, chs[i]});
            rd_chk(`ACS_OFS_DATA, expv(chs[i]));
            rd_chk(`ACS_OFS_CTRL, {27'h0, chs[i]});
        end
        repeat (150) @(posedge clk);
        rd_chk(`ACS_OFS_CTRL, 32'h1E);
        // continuous results overwrite unread ones
        wr(`ACS_OFS_CTRL, 32'h22);
        repeat (80) @(posedge clk);
        levels[23:16] <= 8'h11;
        repeat (160) @(posedge clk);
        rd_chk(`ACS_OFS_DATA, 32'h11);
        wr(`ACS_OFS_CTRL, 32'h02);
        repeat (80) @(posedge clk);
        rd_chk(`ACS_OFS_DATA, 32'h11);
        repeat (150) @(posedge clk);
        rd_chk(`ACS_OFS_CTRL, 32'h02);
        wr(`ACS_OFS_CTRL, 32'h00);
        repeat (20) @(posedge clk);
        wr(`ACS_OFS_CTRL, 32'h01);
        repeat (80) @(posedge clk);
        rd_chk(`ACS_OFS_DATA, expv(5'h01));
        // stop aborts, exit resumes
        wr(`ACS_OFS_CTRL, 32'h43);
        repeat (20) @(posedge clk);
        stop <= 1'b1;
        repeat (200) @(posedge clk);
        check(irq, 1'b0);
        stop <= 1'b0;
        wait_irq();
        check(n <= 74, 1'b1);
        rd_chk(`ACS_OFS_DATA, expv(5'h03));
        // pin sharing
        wr(`ACS_OFS_DIR, 32'h0F);
        wr(`ACS_OFS_PORT, 32'hA5);
        wr(`ACS_OFS_CTRL, 32'h00);
        repeat (3) @(posedge clk);
        check(pins_o, 8'hA4);
        check(pins_oe, 8'h0E);
        check(sel, 8'h01);
        rd_chk(`ACS_OFS_PORT, 32'hF4);
        wr(`ACS_OFS_CTRL, 32'h1F);
        repeat (3) @(posedge clk);
        check(pins_o, 8'hA5);
        check(sel, 8'h00);
        check(core.power, 1'b0);
        // crystal source divided by one
        wr(`ACS_OFS_CLK, 32'h00);
        wr(`ACS_OFS_CTRL, 32'h1E);
        repeat (200) @(posedge clk);
        rd_chk(`ACS_OFS_CTRL, 32'h9E);
        rd_chk(`ACS_OFS_DATA, 32'h00);
        final_report();
    end
endmodule
`default_nettype wire
